// >>> hdl/cs3_decimator.sv
`timescale 1ns/1ps
`include "cs3_defines.svh"

module cs3_decimator #(
	parameter int MOD_DIV = `CS3_MOD_DIV,
	parameter int ACC_W   = `CS3_ACC_W
) (
	input  wire logic                  MCLK,
	input  wire logic                  RST_N,
	input  wire logic                  MOD_BIT,
	input  wire logic                  CHOP_INHIBIT,
	input  wire logic                  DEC_WORD_WE,
	input  wire logic [`CS3_DEC_W-1:0] DEC_WORD_IN,
	output logic [`CS3_DEC_W-1:0]      DEC_WORD,
	output logic                       INPUT_SWAP,
	output logic                       MOD_CE,
	output logic signed [ACC_W-1:0]    DATA,
	output logic                       DATA_VALID
);

	localparam int DIV_W = $clog2(MOD_DIV);

	//------------------------------------------------------------------
	// state
	//------------------------------------------------------------------
	logic [`CS3_DEC_W-1:0]    dec_word_ff;
	logic                     inhibit_ff;
	logic [DIV_W-1:0]         div_cnt_ff;
	logic                     mod_ce_ff;
	logic                     swap_ff;
	logic                     prev_ok_ff;
	logic signed [ACC_W-1:0]  prev_ff;
	logic signed [ACC_W-1:0]  data_ff;
	logic                     data_valid_ff;
	cs3_pkg::cs3_phase_e      phase_ff;
	cs3_pkg::cs3_phase_e      nxt_phase;
	logic                     restart;
	logic                     word_change;
	logic [`CS3_RATIO_W-1:0]  ratio;
	logic signed [ACC_W-1:0]  raw;
	logic                     raw_valid;
	logic signed [ACC_W-1:0]  corr;
	logic signed [ACC_W:0]    pair_sum;
	logic                     take;

	//------------------------------------------------------------------
	// configuration and restart detect
	//------------------------------------------------------------------
	// a write of the value already held is no change
	assign word_change = DEC_WORD_WE && (DEC_WORD_IN != dec_word_ff);
	assign restart     = word_change || (CHOP_INHIBIT != inhibit_ff);

	// decimation word register, reset to 69
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			dec_word_ff <= `CS3_DEC_RESET;
		end else if (DEC_WORD_WE) begin
			dec_word_ff <= DEC_WORD_IN;
		end
	end

	// chop setting tracked to spot changes, chopping after reset
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			inhibit_ff <= 1'b0;
		end else begin
			inhibit_ff <= CHOP_INHIBIT;
		end
	end

	//------------------------------------------------------------------
	// modulator rate enable
	//------------------------------------------------------------------
	// one-cycle pulse at the modulator rate
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			div_cnt_ff <= '0;
			mod_ce_ff  <= 1'b0;
		end else if (div_cnt_ff == DIV_W'(MOD_DIV - 1)) begin
			div_cnt_ff <= '0;
			mod_ce_ff  <= 1'b1;
		end else begin
			div_cnt_ff <= div_cnt_ff + 1'b1;
			mod_ce_ff  <= 1'b0;
		end
	end

	//------------------------------------------------------------------
	// sinc3 filter
	//------------------------------------------------------------------
	// ratio is word times eight
	assign ratio = {dec_word_ff, {`CS3_DEC_MULT_SH{1'b0}}};

	// raw bit enters the filter, flipped while the inputs are reversed
	cs3_sinc3 #(
		.ACC_W   (ACC_W),
		.RATIO_W (`CS3_RATIO_W)
	) u_sinc3 (
		.clk        (MCLK),
		.rst_n      (RST_N),
		.clr        (restart),
		.ce         (mod_ce_ff),
		.x_bit      (MOD_BIT ^ swap_ff),
		.ratio      (ratio),
		.y_ff       (raw),
		.y_valid_ff (raw_valid)
	);

	//------------------------------------------------------------------
	// output slot sequencing
	//------------------------------------------------------------------
	// two unsettled outputs after each reversal, third one is used
	always_comb begin
		nxt_phase = phase_ff;
		case (phase_ff)
			cs3_pkg::CS3_PH_DISCARD0: nxt_phase = cs3_pkg::CS3_PH_DISCARD1;
			cs3_pkg::CS3_PH_DISCARD1: nxt_phase = cs3_pkg::CS3_PH_TAKE;
			cs3_pkg::CS3_PH_TAKE:     nxt_phase = cs3_pkg::CS3_PH_DISCARD0;
			default:                  nxt_phase = cs3_pkg::CS3_PH_DISCARD0;
		endcase
	end

	// chopped: one word per three decimations; inhibited: every one
	assign take = raw_valid && (inhibit_ff || (phase_ff == cs3_pkg::CS3_PH_TAKE));

	// slot counter
	always_ff @(posedge MCLK) begin
		if (!RST_N || restart) begin
			phase_ff <= cs3_pkg::CS3_PH_DISCARD0;
		end else if (raw_valid && !inhibit_ff) begin
			phase_ff <= nxt_phase;
		end
	end

	// reverse inputs after each used output, a full chop cycle spans two
	always_ff @(posedge MCLK) begin
		if (!RST_N || restart) begin
			swap_ff <= 1'b0;
		end else if (take && !inhibit_ff) begin
			swap_ff <= ~swap_ff;
		end
	end

	//------------------------------------------------------------------
	// averaging stage
	//------------------------------------------------------------------
	// the bit flip already restores signal sign; offsets now alternate
	assign corr     = raw;
	assign pair_sum = {corr[ACC_W-1], corr} + {prev_ff[ACC_W-1], prev_ff};

	// keep previous output for pairing
	always_ff @(posedge MCLK) begin
		if (!RST_N || restart) begin
			prev_ff    <= '0;
			prev_ok_ff <= 1'b0;
		end else if (take) begin
			prev_ff    <= corr;
			prev_ok_ff <= 1'b1;
		end
	end

	// data register and strobe, first chopped word waits for a partner
	always_ff @(posedge MCLK) begin
		if (!RST_N || restart) begin
			data_ff       <= '0;
			data_valid_ff <= 1'b0;
		end else begin
			data_valid_ff <= 1'b0;
			if (take && inhibit_ff) begin
				data_ff       <= corr;
				data_valid_ff <= 1'b1;
			end else if (take && prev_ok_ff) begin
				data_ff       <= pair_sum[ACC_W:1];
				data_valid_ff <= 1'b1;
			end
		end
	end

	//------------------------------------------------------------------
	// outputs
	//------------------------------------------------------------------
	assign DEC_WORD   = dec_word_ff;
	assign INPUT_SWAP = swap_ff;
	assign MOD_CE     = mod_ce_ff;
	assign DATA       = data_ff;
	assign DATA_VALID = data_valid_ff;

endmodule : cs3_decimator

// >>> hdl/cs3_defines.svh
`ifndef CS3_DEFINES_SVH
`define CS3_DEFINES_SVH

//----------------------------------------------------------------------
// rates and timing counts
//----------------------------------------------------------------------
`define CS3_CLK_HZ        250000000
`define CS3_MOD_RATE_HZ   32768
`define CS3_MOD_DIV       (`CS3_CLK_HZ / `CS3_MOD_RATE_HZ)

//----------------------------------------------------------------------
// decimation word
//----------------------------------------------------------------------
`define CS3_DEC_W         8
`define CS3_DEC_RESET     8'h45
`define CS3_DEC_MULT_SH   3
`define CS3_RATIO_W       11

//----------------------------------------------------------------------
// filter word width
//----------------------------------------------------------------------
`define CS3_ACC_W         36

`endif

// >>> hdl/cs3_pkg.sv
`include "cs3_defines.svh"

package cs3_pkg;

	// filter output slots within one chop half-period
	typedef enum logic [1:0] {
		CS3_PH_DISCARD0,
		CS3_PH_DISCARD1,
		CS3_PH_TAKE
	} cs3_phase_e;

	typedef logic signed [`CS3_ACC_W-1:0] cs3_word_t;

endpackage : cs3_pkg

// >>> hdl/cs3_sinc3.sv
`timescale 1ns/1ps
`include "cs3_defines.svh"

module cs3_sinc3 #(
	parameter int ACC_W   = `CS3_ACC_W,
	parameter int RATIO_W = `CS3_RATIO_W
) (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    clr,
	input  wire logic                    ce,
	input  wire logic                    x_bit,
	input  wire logic [RATIO_W-1:0]      ratio,
	output logic signed [ACC_W-1:0]      y_ff,
	output logic                         y_valid_ff
);

	//------------------------------------------------------------------
	// integrators and comb delays
	//------------------------------------------------------------------
	logic signed [ACC_W-1:0] int_ff [3];
	logic signed [ACC_W-1:0] dly_ff [3];
	logic signed [ACC_W-1:0] comb   [3];
	logic        [RATIO_W-1:0] cnt_ff;
	logic signed [ACC_W-1:0] x_val;
	logic signed [ACC_W-1:0] int_sum;
	logic                    dec_tick;

	// single bit mapped to +1 or -1
	assign x_val    = {{(ACC_W-1){~x_bit}}, 1'b1};
	assign dec_tick = ce && (cnt_ff == ratio - 1'b1);

	// comb taps the last integrator's next value: the window of an output then ends two
	// samples back, so after a clear or a reversal the third output holds no stale sample
	assign int_sum = int_ff[2] + int_ff[1];

	// three cascaded comb differences
	assign comb[0] = int_sum - dly_ff[0];
	assign comb[1] = comb[0] - dly_ff[1];
	assign comb[2] = comb[1] - dly_ff[2];

	// integrator chain, modulo arithmetic cancels in the combs
	always_ff @(posedge clk) begin
		if (!rst_n || clr) begin
			int_ff[0] <= '0;
			int_ff[1] <= '0;
			int_ff[2] <= '0;
		end else if (ce) begin
			int_ff[0] <= int_ff[0] + x_val;
			int_ff[1] <= int_ff[1] + int_ff[0];
			int_ff[2] <= int_ff[2] + int_ff[1];
		end
	end

	// decimation counter
	always_ff @(posedge clk) begin
		if (!rst_n || clr) begin
			cnt_ff <= '0;
		end else if (dec_tick) begin
			cnt_ff <= '0;
		end else if (ce) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// comb section runs at the decimated rate
	always_ff @(posedge clk) begin
		if (!rst_n || clr) begin
			dly_ff[0]  <= '0;
			dly_ff[1]  <= '0;
			dly_ff[2]  <= '0;
			y_ff       <= '0;
			y_valid_ff <= 1'b0;
		end else begin
			y_valid_ff <= dec_tick;
			if (dec_tick) begin
				dly_ff[0] <= int_sum;
				dly_ff[1] <= comb[0];
				dly_ff[2] <= comb[1];
				y_ff      <= comb[2];
			end
		end
	end

endmodule : cs3_sinc3

// >>> tb/cs3_decimator_assertions.sv
`timescale 1ns/1ps

module cs3_chk #(
	parameter int MOD_DIV = 4,
	parameter int ACC_W   = 36
) (
	input wire logic                    MCLK,
	input wire logic                    RST_N,
	input wire logic                    CHOP_INHIBIT,
	input wire logic                    DEC_WORD_WE,
	input wire logic [7:0]              DEC_WORD_IN,
	input wire logic [7:0]              DEC_WORD,
	input wire logic                    INPUT_SWAP,
	input wire logic                    MOD_CE,
	input wire logic signed [ACC_W-1:0] DATA,
	input wire logic                    DATA_VALID
);
	int   gap_ff;
	logic seen_ff;

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// clocks since the last modulator strobe
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			gap_ff <= 0;
			seen_ff <= 1'b0;
		end else begin
			gap_ff <= MOD_CE ? 0 : gap_ff + 1;
			seen_ff <= seen_ff | MOD_CE;
		end
	end

	property p_word_load; DEC_WORD_WE |=> DEC_WORD == $past(DEC_WORD_IN); endproperty
	a_word_load: assert property (p_word_load) else $error("word not loaded");
	property p_word_hold; !DEC_WORD_WE |=> $stable(DEC_WORD); endproperty
	a_word_hold: assert property (p_word_hold) else $error("word moved");
	property p_valid_pulse; DATA_VALID |=> !DATA_VALID; endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
	property p_data_hold; $changed(DATA) |-> DATA_VALID || DATA == '0; endproperty
	a_data_hold: assert property (p_data_hold) else $error("data without valid");
	property p_valid_ce; DATA_VALID |-> $past(MOD_CE, 2); endproperty
	a_valid_ce: assert property (p_valid_ce) else $error("valid off strobe");
	property p_ce_gap; MOD_CE && seen_ff |-> gap_ff == MOD_DIV - 1; endproperty
	a_ce_gap: assert property (p_ce_gap) else $error("strobe spacing");
	property p_nochop_swap; CHOP_INHIBIT |=> !INPUT_SWAP; endproperty
	a_nochop_swap: assert property (p_nochop_swap) else $error("swap with chop off");
	property p_restart_word;
		DEC_WORD_WE && DEC_WORD_IN != DEC_WORD |=> DATA == '0 && !INPUT_SWAP && !DATA_VALID;
	endproperty
	a_restart_word: assert property (p_restart_word) else $error("no restart on word");
	property p_restart_chop;
		$changed(CHOP_INHIBIT) |=> DATA == '0 && !INPUT_SWAP && !DATA_VALID;
	endproperty
	a_restart_chop: assert property (p_restart_chop) else $error("no restart on chop");
endmodule : cs3_chk

bind cs3_decimator cs3_chk #(.MOD_DIV(MOD_DIV), .ACC_W(ACC_W)) u_chk (.MCLK(MCLK),
	.RST_N(RST_N), .CHOP_INHIBIT(CHOP_INHIBIT), .DEC_WORD_WE(DEC_WORD_WE),
	.DEC_WORD_IN(DEC_WORD_IN), .DEC_WORD(DEC_WORD), .INPUT_SWAP(INPUT_SWAP),
	.MOD_CE(MOD_CE), .DATA(DATA), .DATA_VALID(DATA_VALID));

// >>> tb/cs3_mod_model.sv
`timescale 1ns/1ps

module cs3_mod_model (
	input  wire logic       MCLK,
	input  wire logic       MOD_CE,
	input  wire logic       INPUT_SWAP,
	input  wire logic [1:0] MODE,
	output logic            MOD_BIT
);
	logic alt_ff = 1'b0;

	// zero-mean pattern, one step per modulator sample
	always @(posedge MCLK) begin
		if (MOD_CE) begin
			alt_ff <= !alt_ff;
		end
	end

	// swapped inputs invert the stream; mode 2 carries an offset of half scale
	assign MOD_BIT = INPUT_SWAP ^ (MODE[1] ? (INPUT_SWAP ? alt_ff : 1'b1) : MODE[0]);
endmodule : cs3_mod_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	localparam int DIV = 4;
	logic               mclk;
	logic               rst_n;
	logic               mod_bit;
	logic               chop_inhibit;
	logic               dec_we;
	logic [7:0]         dec_in;
	logic [7:0]         dec_word;
	logic               input_swap;
	logic               mod_ce;
	cs3_pkg::cs3_word_t data;
	logic               data_valid;
	logic [1:0]         mode;
	int                 err_total;
	int                 cmp_count;

	cs3_decimator #(.MOD_DIV(DIV)) uut (.MCLK(mclk), .RST_N(rst_n), .MOD_BIT(mod_bit),
		.CHOP_INHIBIT(chop_inhibit), .DEC_WORD_WE(dec_we), .DEC_WORD_IN(dec_in),
		.DEC_WORD(dec_word), .INPUT_SWAP(input_swap), .MOD_CE(mod_ce), .DATA(data),
		.DATA_VALID(data_valid));
	cs3_mod_model u_mod (.MCLK(mclk), .MOD_CE(mod_ce), .INPUT_SWAP(input_swap),
		.MODE(mode), .MOD_BIT(mod_bit));

	// free-running 250 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic chk(input cs3_pkg::cs3_word_t got, input cs3_pkg::cs3_word_t exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %0d exp %0d", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		if (err_total == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// counts falling edges up to the next result strobe
	task automatic wait_valid(output int cyc);
		cyc = 0;
		do begin
			@(negedge mclk);
			cyc++;
		end while (data_valid !== 1'b1 && cyc < 9000);
		if (cyc >= 9000) begin
			err_total++;
			final_report();
		end
	endtask : wait_valid

	task automatic set_word(input logic [7:0] v);
		@(negedge mclk);
		dec_we = 1'b1;
		dec_in = v;
		@(negedge mclk);
		dec_we = 1'b0;
		chk(dec_word, v);
		chk(data, 0);
		chk(input_swap, 1'b0);
	endtask : set_word

	task automatic t_reset;
		chk(dec_word, 8'h45);
		chk(input_swap, 1'b0);
		chk(data_valid, 1'b0);
	endtask : t_reset

	task automatic t_chop13;
		int   c;
		logic s;
		mode = 2'd1;
		set_word(8'd13);
		wait_valid(c);
		chk(data, 104 * 104 * 104);
		repeat (8) @(negedge mclk);
		s = input_swap;
		wait_valid(c);
		chk(c, 3 * 8 * 13 * DIV - 8);
		chk(data, 104 * 104 * 104);
		repeat (8) @(negedge mclk);
		chk(input_swap, !s);
	endtask : t_chop13

	task automatic t_offset;
		int c;
		mode = 2'd2;
		set_word(8'd3);
		wait_valid(c);
		chk(data, 24 * 24 * 24 / 2);
		wait_valid(c);
		chk(c, 3 * 24 * DIV);
		chk(data, 24 * 24 * 24 / 2);
		@(negedge mclk);
		dec_we = 1'b1;
		@(negedge mclk);
		dec_we = 1'b0;
		chk(data, 24 * 24 * 24 / 2);
	endtask : t_offset

	task automatic t_nochop;
		int c;
		mode = 2'd0;
		chop_inhibit = 1'b1;
		@(negedge mclk);
		chk(data, 0);
		repeat (3) wait_valid(c);
		chk(c, 24 * DIV);
		chk(data, -24 * 24 * 24);
		chk(input_swap, 1'b0);
	endtask : t_nochop

	// reset in mid-run: word back to default, chopping on again
	task automatic t_rereset;
		int c;
		@(negedge mclk);
		rst_n = 1'b0;
		chop_inhibit = 1'b0;
		mode = 2'd1;
		repeat (8) @(negedge mclk);
		chk(data, 0);
		rst_n = 1'b1;
		t_reset();
		set_word(8'd3);
		wait_valid(c);
		chk(data, 24 * 24 * 24);
	endtask : t_rereset

	// reset, then each scenario in turn
	initial begin
		rst_n = 1'b0;
		chop_inhibit = 1'b0;
		dec_we = 1'b0;
		dec_in = 8'h45;
		mode = 2'd1;
		err_total = 0;
		cmp_count = 0;
		repeat (8) @(negedge mclk);
		rst_n = 1'b1;
		t_reset();
		t_chop13();
		t_offset();
		t_nochop();
		t_rereset();
		final_report();
	end
endmodule : tb_top
